// [rtl/crs_pkg.sv]
// Constants shared by the receiver control and status register bank
// Overview of operation
// RULE1: Status D5 shows live signal loss
// RULE2: Status D4 shows lock loss, 0 when locked
// RULE3: Status D3 shows signal-loss action completed
// RULE4: Status D2 sticky lock loss until cleared
// RULE5: Status D0 holds measure done until cleared
// RULE6: Mode D6:D4: 000 data, 010 reference
// RULE7: Control A D2 write 1 clears sticky
// RULE8: Control A D1 write 1 starts measurement
// RULE9: Control A D0 write 1 clears measurement
// RULE10: Control B D7 one-then-zero resets device
// RULE11: Control B D6 one-then-zero restarts acquisition
// RULE12: Control B D5 set bypasses recovery path
// RULE13: Control B D3 set powers detector down
// RULE14: Control B D2 inverts signal-loss pin
// RULE15: Control C D2 powers reference input down
// RULE16: D6 picks lock compare source
// RULE17: D5:D4 selects reference band, doubling
// RULE18: D3:D0 code n gives ratio 2^(n-1)
// RULE19: Rate over ratio equals reference over band
// RULE20: Host writes reserved bits 0, C D0 1
package crs_pkg;
    localparam logic [7:0] ADDR_STATUS = 8'h06;
    localparam logic [7:0] ADDR_CTRL_A = 8'h08;
    localparam logic [7:0] ADDR_CTRL_B = 8'h09;
    localparam logic [7:0] ADDR_CTRL_C = 8'h0A;
    localparam logic [7:0] ADDR_REF_SETUP = 8'h0F;
    localparam logic [7:0] ADDR_SEED_B0 = 8'h42;
    localparam logic [7:0] ADDR_SEED_B1 = 8'h43;
    localparam logic [7:0] ADDR_SEED_B2 = 8'h44;
    localparam logic [7:0] ADDR_SEED_B3 = 8'h45;
    localparam logic [7:0] ADDR_REVISION = 8'h48;
    localparam logic [7:0] ADDR_IDENTITY = 8'h49;
    localparam int ST_SIGNAL_LOSS = 5;
    localparam int ST_LOCK_LOSS = 4;
    localparam int ST_ACTION_DONE = 3;
    localparam int ST_STICKY_UNLOCK = 2;
    localparam int ST_MEASURE_DONE = 0;
    localparam int CA_MODE_LSB = 4;
    localparam int CA_STICKY_CLEAR = 2;
    localparam int CA_MEASURE_START = 1;
    localparam int CA_MEASURE_CLEAR = 0;
    localparam int CB_DEVICE_RESET = 7;
    localparam int CB_ACQ_RESTART = 6;
    localparam int CB_PATH_SKIP = 5;
    localparam int CB_STATIC_LOCK = 4;
    localparam int CB_DETECTOR_OFF = 3;
    localparam int CB_PIN_SENSE = 2;
    localparam int CC_REF_OFF = 2;
    localparam int RS_COMPARE_SRC = 6;
    localparam int RS_BAND_LSB = 4;
    localparam int RS_MULT_LSB = 0;
    localparam logic [7:0] CTRL_A_MASK = 8'h77;
    localparam logic [7:0] CTRL_B_MASK = 8'hFC;
    localparam logic [7:0] CTRL_C_MASK = 8'h05;
    localparam logic [7:0] REF_SETUP_MASK = 8'h7F;
    localparam logic [7:0] CTRL_A_RESET = 8'h00;
    localparam logic [7:0] CTRL_B_RESET = 8'h00;
    localparam logic [7:0] CTRL_C_RESET = 8'h05;
    localparam logic [7:0] REF_SETUP_RESET = 8'h00;
    localparam logic [2:0] MODE_LOCK_TO_DATA = 3'h0;
    localparam logic [2:0] MODE_LOCK_TO_REFERENCE = 3'h2;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_ADDR = 4'b0001,
        ST_ACK_ADDR = 4'b0010,
        ST_PTR = 4'b0011,
        ST_ACK_PTR = 4'b0100,
        ST_WDATA = 4'b0101,
        ST_ACK_DATA = 4'b0110,
        ST_RDATA = 4'b0111,
        ST_RACK = 4'b1000
    } crs_i2c_state_t;
endpackage

// [rtl/crs_i2c_target.sv]
// Serial management target: byte framing, pointer and write strobes
`timescale 1ns/100ps
module crs_i2c_target #(
    parameter logic [6:0] DEV_ADDR = 7'h2A
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_oe,
    output logic o_wr_stb,
    output logic [7:0] o_addr,
    output logic [7:0] o_wr_data,
    input wire logic [7:0] i_rd_data
);
    crs_pkg::crs_i2c_state_t state_reg, state_next;
    logic scl_q, sda_q;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] ptr_reg, ptr_next;
    logic oe_reg, oe_next;
    logic rw_reg, rw_next;
    logic ack_reg, ack_next;
    logic wr_reg, wr_next;

    wire start = i_scl & scl_q & sda_q & ~i_sda;
    wire stop = i_scl & scl_q & ~sda_q & i_sda;
    wire scl_rise = i_scl & ~scl_q;
    wire scl_fall = ~i_scl & scl_q;
    wire full = (cnt_reg == crs_pkg::BYTE_BITS);
    wire receiving = (state_reg == crs_pkg::ST_ADDR) | (state_reg == crs_pkg::ST_PTR)
                     | (state_reg == crs_pkg::ST_WDATA);
    wire load_now = ((state_reg == crs_pkg::ST_ACK_ADDR) & rw_reg)
                    | ((state_reg == crs_pkg::ST_RACK) & ack_reg);

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        shift_next = shift_reg;
        ptr_next = ptr_reg;
        oe_next = oe_reg;
        rw_next = rw_reg;
        ack_next = ack_reg;
        wr_next = 1'b0;
        if (stop) begin
            state_next = crs_pkg::ST_IDLE;
            oe_next = 1'b0;
        end else if (start) begin
            // Repeated start is accepted anywhere and keeps the pointer
            state_next = crs_pkg::ST_ADDR;
            cnt_next = 4'h0;
            oe_next = 1'b0;
        end else if (scl_rise) begin
            if (receiving && !full) begin
                shift_next = {shift_reg[6:0], i_sda};
                cnt_next = cnt_reg + 4'h1;
            end
            if (state_reg == crs_pkg::ST_RACK) begin
                ack_next = ~i_sda;
            end
        end else if (scl_fall) begin
            unique case (state_reg)
                crs_pkg::ST_IDLE: begin
                end
                crs_pkg::ST_ADDR: begin
                    if (full && shift_reg[7:1] == DEV_ADDR) begin
                        oe_next = 1'b1;
                        rw_next = shift_reg[0];
                        state_next = crs_pkg::ST_ACK_ADDR;
                    end else if (full) begin
                        state_next = crs_pkg::ST_IDLE;
                    end
                end
                crs_pkg::ST_ACK_ADDR, crs_pkg::ST_RACK: begin
                    if (load_now) begin
                        // Read data is snapshotted here, then the pointer advances
                        shift_next = i_rd_data;
                        oe_next = ~i_rd_data[7];
                        cnt_next = 4'h1;
                        ptr_next = ptr_reg + 8'h01;
                        state_next = crs_pkg::ST_RDATA;
                    end else if (state_reg == crs_pkg::ST_ACK_ADDR) begin
                        oe_next = 1'b0;
                        cnt_next = 4'h0;
                        state_next = crs_pkg::ST_PTR;
                    end else begin
                        state_next = crs_pkg::ST_IDLE;
                    end
                end
                crs_pkg::ST_PTR: begin
                    if (full) begin
                        ptr_next = shift_reg;
                        oe_next = 1'b1;
                        state_next = crs_pkg::ST_ACK_PTR;
                    end
                end
                crs_pkg::ST_ACK_PTR, crs_pkg::ST_ACK_DATA: begin
                    if (state_reg == crs_pkg::ST_ACK_DATA) begin
                        ptr_next = ptr_reg + 8'h01;
                    end
                    oe_next = 1'b0;
                    cnt_next = 4'h0;
                    state_next = crs_pkg::ST_WDATA;
                end
                crs_pkg::ST_WDATA: begin
                    if (full) begin
                        wr_next = 1'b1;
                        oe_next = 1'b1;
                        state_next = crs_pkg::ST_ACK_DATA;
                    end
                end
                crs_pkg::ST_RDATA: begin
                    if (full) begin
                        oe_next = 1'b0;
                        state_next = crs_pkg::ST_RACK;
                    end else begin
                        shift_next = {shift_reg[6:0], 1'b0};
                        oe_next = ~shift_reg[6];
                        cnt_next = cnt_reg + 4'h1;
                    end
                end
                default: begin
                    state_next = crs_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg <= crs_pkg::ST_IDLE;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            ptr_reg <= 8'h00;
            oe_reg <= 1'b0;
            rw_reg <= 1'b0;
            ack_reg <= 1'b0;
            wr_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            scl_q <= i_scl;
            sda_q <= i_sda;
            cnt_reg <= cnt_next;
            shift_reg <= shift_next;
            ptr_reg <= ptr_next;
            oe_reg <= oe_next;
            rw_reg <= rw_next;
            ack_reg <= ack_next;
            wr_reg <= wr_next;
        end
    end

    assign o_sda_oe = oe_reg;
    assign o_wr_stb = wr_reg;
    assign o_addr = ptr_reg;
    assign o_wr_data = shift_reg;
endmodule

// [rtl/crs_regs_top.sv]
// Receiver control and status register bank behind the serial management port
`timescale 1ns/100ps
module crs_regs_top #(
    parameter logic [6:0] DEV_ADDR = 7'h2A,
    // Arbitrary neutral codes
    parameter logic [7:0] REVISION_CODE = 8'h11,
    parameter logic [7:0] IDENTITY_CODE = 8'h22
) (
    input wire logic I_CLK,
    input wire logic I_RESETN,
    input wire logic I_SCL,
    input wire logic I_SDA,
    output logic O_SDA_OUT,
    output logic O_SDA_OE,
    input wire logic I_SIGNAL_LOSS,
    input wire logic I_LOCK_LOSS,
    input wire logic I_SIGNAL_ACTION_FINISHED,
    input wire logic I_RATE_MEASURE_DONE,
    input wire logic [31:0] I_PATTERN_SEED_READBACK,
    output logic O_SIGNAL_LOSS_PIN,
    output logic [2:0] O_RECOVERY_LOOP_SELECT,
    output logic O_LOCK_TO_REFERENCE,
    output logic O_RATE_MEASURE_START,
    output logic O_RATE_MEASURE_CLEAR,
    output logic O_ACQUISITION_RESTART,
    output logic O_DEVICE_RESET,
    output logic O_RECOVERY_PATH_SKIP,
    output logic O_STATIC_LOCK_MODE,
    output logic O_SIGNAL_DETECTOR_OFF,
    output logic O_REFERENCE_INPUT_OFF,
    output logic O_LOCK_COMPARE_SOURCE,
    output logic [1:0] O_REFERENCE_BAND,
    output logic [3:0] O_RATE_MULTIPLE,
    output logic signed [4:0] O_RATE_TO_REF_EXP
);
    // General call and high reserved target addresses cannot be served
    if (DEV_ADDR < 7'h08 || DEV_ADDR > 7'h77) begin : g_bad_addr
        $error("DEV_ADDR lies in a reserved range");
    end

    function automatic logic [7:0] next_field(
        input logic [7:0] cur,
        input logic wr,
        input logic [7:0] data,
        input logic [7:0] mask,
        input logic [7:0] rst_val,
        input logic srst
    );
        logic [7:0] val;
        val = wr ? (data & mask) : cur;
        return srst ? rst_val : val;
    endfunction

    // Log2 of data rate over reference clock
    function automatic logic signed [4:0] rate_exp(
        input logic [3:0] mult,
        input logic [1:0] band
    );
        return $signed({1'b0, mult}) - 5'sd1 - $signed({3'b000, band});
    endfunction

    logic wr_stb;
    logic [7:0] addr;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic sda_oe;

    crs_i2c_target #(
        .DEV_ADDR(DEV_ADDR)
    ) u_target (
        .i_clk(I_CLK),
        .i_resetn(I_RESETN),
        .i_scl(I_SCL),
        .i_sda(I_SDA),
        .o_sda_oe(sda_oe),
        .o_wr_stb(wr_stb),
        .o_addr(addr),
        .o_wr_data(wr_data),
        .i_rd_data(rd_data)
    );

    logic [7:0] ctrl_a_reg, ctrl_a_next;
    logic [7:0] ctrl_b_reg, ctrl_b_next;
    logic [7:0] ctrl_c_reg, ctrl_c_next;
    logic [7:0] ref_setup_reg, ref_setup_next;
    logic sloss_reg, lloss_reg, action_done_reg;
    logic sticky_reg, sticky_next;
    logic done_reg, done_next;
    logic pin_reg, rlock_reg;
    logic start_reg, clear_reg, restart_reg, srst_reg;
    logic signed [4:0] exp_reg;
    logic sda_out_reg;

    wire wr_a = wr_stb & (addr == crs_pkg::ADDR_CTRL_A);
    wire wr_b = wr_stb & (addr == crs_pkg::ADDR_CTRL_B);
    wire wr_c = wr_stb & (addr == crs_pkg::ADDR_CTRL_C);
    wire wr_ref = wr_stb & (addr == crs_pkg::ADDR_REF_SETUP);
    // One-then-zero sequences act on the write of the zero
    wire srst_hit = wr_b & ctrl_b_reg[crs_pkg::CB_DEVICE_RESET]
                    & ~wr_data[crs_pkg::CB_DEVICE_RESET]; // see RULE10
    wire restart_hit = wr_b & ctrl_b_reg[crs_pkg::CB_ACQ_RESTART]
                       & ~wr_data[crs_pkg::CB_ACQ_RESTART]; // see RULE11
    wire sticky_clr = wr_a & wr_data[crs_pkg::CA_STICKY_CLEAR]; // see RULE7
    wire measure_go = wr_a & wr_data[crs_pkg::CA_MEASURE_START]; // see RULE8
    wire measure_clr = wr_a & wr_data[crs_pkg::CA_MEASURE_CLEAR]; // see RULE9
    wire detector_off = ctrl_b_reg[crs_pkg::CB_DETECTOR_OFF];
    // A powered-down detector never reports loss
    wire sloss_eff = I_SIGNAL_LOSS & ~detector_off; // see RULE13

    assign ctrl_a_next = next_field(ctrl_a_reg, wr_a, wr_data,
        crs_pkg::CTRL_A_MASK, crs_pkg::CTRL_A_RESET, srst_hit);
    assign ctrl_b_next = next_field(ctrl_b_reg, wr_b, wr_data,
        crs_pkg::CTRL_B_MASK, crs_pkg::CTRL_B_RESET, srst_hit);
    assign ctrl_c_next = next_field(ctrl_c_reg, wr_c, wr_data,
        crs_pkg::CTRL_C_MASK, crs_pkg::CTRL_C_RESET, srst_hit);
    assign ref_setup_next = next_field(ref_setup_reg, wr_ref, wr_data,
        crs_pkg::REF_SETUP_MASK, crs_pkg::REF_SETUP_RESET, srst_hit);
    // New events win over a clear in the same cycle
    assign sticky_next = I_LOCK_LOSS | (sticky_reg & ~sticky_clr & ~srst_hit); // see RULE4
    assign done_next = I_RATE_MEASURE_DONE | (done_reg & ~measure_clr & ~srst_hit); // see RULE5

    wire [2:0] mode_next = ctrl_a_next[crs_pkg::CA_MODE_LSB +: 3];
    wire [7:0] status_word = {2'b00, sloss_reg, lloss_reg, action_done_reg,
                              sticky_reg, 1'b0, done_reg}; // see RULE1, RULE2, RULE3

    always_comb begin
        unique case (addr)
            crs_pkg::ADDR_STATUS: rd_data = status_word;
            crs_pkg::ADDR_CTRL_A: rd_data = ctrl_a_reg;
            crs_pkg::ADDR_CTRL_B: rd_data = ctrl_b_reg;
            crs_pkg::ADDR_CTRL_C: rd_data = ctrl_c_reg;
            crs_pkg::ADDR_REF_SETUP: rd_data = ref_setup_reg;
            crs_pkg::ADDR_SEED_B0: rd_data = I_PATTERN_SEED_READBACK[7:0];
            crs_pkg::ADDR_SEED_B1: rd_data = I_PATTERN_SEED_READBACK[15:8];
            crs_pkg::ADDR_SEED_B2: rd_data = I_PATTERN_SEED_READBACK[23:16];
            crs_pkg::ADDR_SEED_B3: rd_data = I_PATTERN_SEED_READBACK[31:24];
            crs_pkg::ADDR_REVISION: rd_data = REVISION_CODE;
            crs_pkg::ADDR_IDENTITY: rd_data = IDENTITY_CODE;
            default: rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            ctrl_a_reg <= crs_pkg::CTRL_A_RESET;
            ctrl_b_reg <= crs_pkg::CTRL_B_RESET;
            ctrl_c_reg <= crs_pkg::CTRL_C_RESET;
            ref_setup_reg <= crs_pkg::REF_SETUP_RESET;
        end else begin
            ctrl_a_reg <= ctrl_a_next; // see RULE6
            ctrl_b_reg <= ctrl_b_next; // see RULE12, RULE14
            ctrl_c_reg <= ctrl_c_next; // see RULE15
            ref_setup_reg <= ref_setup_next; // see RULE16, RULE17, RULE18
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            sloss_reg <= 1'b0;
            lloss_reg <= 1'b0;
            action_done_reg <= 1'b0;
            sticky_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            sloss_reg <= sloss_eff; // see RULE1
            lloss_reg <= I_LOCK_LOSS; // see RULE2
            action_done_reg <= I_SIGNAL_ACTION_FINISHED; // see RULE3
            sticky_reg <= sticky_next;
            done_reg <= done_next;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            pin_reg <= 1'b0;
            rlock_reg <= 1'b0;
            start_reg <= 1'b0;
            clear_reg <= 1'b0;
            restart_reg <= 1'b0;
            srst_reg <= 1'b0;
            exp_reg <= 5'sh0;
            sda_out_reg <= 1'b0;
        end else begin
            pin_reg <= sloss_eff ^ ctrl_b_reg[crs_pkg::CB_PIN_SENSE]; // see RULE14
            rlock_reg <= (mode_next == crs_pkg::MODE_LOCK_TO_REFERENCE); // see RULE6
            start_reg <= measure_go; // see RULE8
            clear_reg <= measure_clr; // see RULE9
            restart_reg <= restart_hit; // see RULE11
            srst_reg <= srst_hit; // see RULE10
            exp_reg <= rate_exp(ref_setup_next[crs_pkg::RS_MULT_LSB +: 4],
                                ref_setup_next[crs_pkg::RS_BAND_LSB +: 2]); // see RULE19
            sda_out_reg <= 1'b0;
        end
    end

    assign O_SDA_OUT = sda_out_reg;
    assign O_SDA_OE = sda_oe;
    assign O_SIGNAL_LOSS_PIN = pin_reg;
    assign O_RECOVERY_LOOP_SELECT = ctrl_a_reg[crs_pkg::CA_MODE_LSB +: 3];
    assign O_LOCK_TO_REFERENCE = rlock_reg;
    assign O_RATE_MEASURE_START = start_reg;
    assign O_RATE_MEASURE_CLEAR = clear_reg;
    assign O_ACQUISITION_RESTART = restart_reg;
    assign O_DEVICE_RESET = srst_reg;
    assign O_RECOVERY_PATH_SKIP = ctrl_b_reg[crs_pkg::CB_PATH_SKIP]; // see RULE12
    assign O_STATIC_LOCK_MODE = ctrl_b_reg[crs_pkg::CB_STATIC_LOCK];
    assign O_SIGNAL_DETECTOR_OFF = ctrl_b_reg[crs_pkg::CB_DETECTOR_OFF]; // see RULE13
    assign O_REFERENCE_INPUT_OFF = ctrl_c_reg[crs_pkg::CC_REF_OFF]; // see RULE15
    assign O_LOCK_COMPARE_SOURCE = ref_setup_reg[crs_pkg::RS_COMPARE_SRC]; // see RULE16
    assign O_REFERENCE_BAND = ref_setup_reg[crs_pkg::RS_BAND_LSB +: 2]; // see RULE17
    assign O_RATE_MULTIPLE = ref_setup_reg[crs_pkg::RS_MULT_LSB +: 4]; // see RULE18
    assign O_RATE_TO_REF_EXP = exp_reg;

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESETN);

    AST_SIGNAL_LOSS_STATUS: assert property ( // see RULE1
        ##1 status_word[crs_pkg::ST_SIGNAL_LOSS] == $past(sloss_eff))
        else $error("signal loss status does not follow detector");
    AST_LOCK_STATUS: assert property ( // see RULE2
        I_LOCK_LOSS [*2] |-> status_word[crs_pkg::ST_LOCK_LOSS] && sticky_reg)
        else $error("lock loss status or sticky flag missing");
    AST_ACTION_DONE: assert property ( // see RULE3
        !I_SIGNAL_ACTION_FINISHED |=> !status_word[crs_pkg::ST_ACTION_DONE])
        else $error("action done shown while incomplete");
    AST_STICKY_HOLD: assert property ( // see RULE4
        sticky_reg && !sticky_clr && !srst_hit |=> sticky_reg)
        else $error("sticky unlock flag dropped without clear");
    AST_MEASURE_DONE: assert property ( // see RULE5
        I_RATE_MEASURE_DONE ##1 (!measure_clr && !srst_hit) [*3] |=> done_reg)
        else $error("measure done flag not held");
    AST_MODE_DECODE: assert property ( // see RULE6
        O_LOCK_TO_REFERENCE == (O_RECOVERY_LOOP_SELECT == crs_pkg::MODE_LOCK_TO_REFERENCE))
        else $error("lock to reference does not match mode field");
    AST_STICKY_CLEAR: assert property ( // see RULE7
        sticky_clr && !I_LOCK_LOSS |=> !sticky_reg)
        else $error("sticky flag survived clear");
    AST_MEASURE_START: assert property ( // see RULE8
        O_RATE_MEASURE_START |-> $past(wr_a) && $past(wr_data[crs_pkg::CA_MEASURE_START]))
        else $error("measure start without a write of one");
    AST_MEASURE_CLEAR: assert property ( // see RULE9
        measure_clr && !I_RATE_MEASURE_DONE |=> O_RATE_MEASURE_CLEAR && !done_reg)
        else $error("measurement clear did not act");
    AST_SOFT_RESET: assert property ( // see RULE10
        srst_hit |=> O_DEVICE_RESET && ctrl_b_reg == crs_pkg::CTRL_B_RESET
                     && ctrl_c_reg == crs_pkg::CTRL_C_RESET ##1 !O_DEVICE_RESET)
        else $error("software reset sequence misbehaved");
    AST_ACQ_RESTART: assert property ( // see RULE11
        O_ACQUISITION_RESTART |-> $past(wr_b) && $past(ctrl_b_reg[crs_pkg::CB_ACQ_RESTART]))
        else $error("acquisition restart without one-then-zero");
    AST_PIN_SENSE: assert property ( // see RULE14
        $stable(ctrl_b_reg) && $stable(sloss_eff) |->
            O_SIGNAL_LOSS_PIN == (status_word[crs_pkg::ST_SIGNAL_LOSS] ^ ctrl_b_reg[crs_pkg::CB_PIN_SENSE]))
        else $error("signal loss pin polarity wrong");
    // The exponent is only recomputed one edge after reset release
    AST_RATE_EXP: assert property ( // see RULE19
        $past(I_RESETN) |-> O_RATE_TO_REF_EXP == $signed({1'b0, O_RATE_MULTIPLE}) - 5'sd1
                             - $signed({3'b000, O_REFERENCE_BAND}))
        else $error("rate exponent mismatch");

    COV_SOFT_RESET: cover property (srst_hit ##1 O_DEVICE_RESET);
    COV_STICKY_CLEAR: cover property (sticky_reg ##1 sticky_clr ##1 !sticky_reg);
    COV_MEASURE: cover property (O_RATE_MEASURE_START ##[1:50] done_reg);
    COV_REF_LOCK_MODE: cover property ($rose(O_LOCK_TO_REFERENCE));
endmodule

// [tb/crs_host_model.sv]
// Serial management host model for the register bank's two-wire port
`timescale 1ns/100ps
module crs_host_model #(
    parameter logic [6:0] ADDR = 7'h2A
) (
    input wire logic clk,
    input wire logic dev_oe,
    output logic scl = 1'b1,
    output wire logic sda
);
    logic drv = 1'b1;
    // Pull-up: a released line reads high unless the device pulls it low
    assign sda = drv & ~dev_oe;
    task automatic step(input logic c, input logic d, input int n);
        scl <= c;
        drv <= d;
        repeat (n) @(posedge clk);
    endtask
    // Start is frame(1,0), stop is frame(0,1); data only moves while the clock is low
    task automatic frame(input logic a, input logic b);
        step(1'b0, a, 2);
        step(1'b1, a, 3);
        step(1'b1, b, 3);
    endtask
    // Nine clocks MSB first; the ninth is the acknowledge slot
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            step(1'b0, tx[i], 2);
            step(1'b1, tx[i], 2);
            rx[i] = sda;
            step(1'b1, tx[i], 2);
            step(1'b0, tx[i], 2);
        end
    endtask
    task automatic point(input logic [7:0] a);
        logic [8:0] r;
        frame(1'b1, 1'b0);
        xfer({ADDR, 2'b01}, r);
        xfer({a, 1'b1}, r);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [8:0] r;
        point(a);
        xfer({d, 1'b1}, r);
        frame(1'b0, 1'b1);
    endtask
    // Single byte read ends with a NACK so the target lets go of the line
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        logic [8:0] r;
        point(a);
        frame(1'b1, 1'b0);
        xfer({ADDR, 2'b11}, r);
        xfer(9'h1FF, r);
        d = r[8:1];
        frame(1'b0, 1'b1);
    endtask
endmodule

// [tb/tb_crs_regs_top.sv]
// Self-checking bench for the receiver control and status register bank
`timescale 1ns/100ps
module tb_crs_regs_top;
    logic I_CLK = 1'b0;
    logic I_RESETN = 1'b0;
    logic sig = 1'b0, lck = 1'b0, act = 1'b0, mdone = 1'b0;
    logic scl, sda, oe, pin, rfl, mstart, mclr, acq, srst, skip, slk, detoff, refoff, cmp;
    logic [2:0] sel;
    logic [1:0] band;
    logic [3:0] mult;
    logic signed [4:0] rexp;
    int err_total = 0;
    int checked = 0;
    int pulses [4] = '{0, 0, 0, 0};
    always #25 I_CLK = ~I_CLK;
    crs_host_model i_host (.clk(I_CLK), .dev_oe(oe), .scl(scl), .sda(sda));
    crs_regs_top i_dut (.I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_SCL(scl), .I_SDA(sda), .O_SDA_OUT(), .O_SDA_OE(oe),
        .I_SIGNAL_LOSS(sig), .I_LOCK_LOSS(lck), .I_SIGNAL_ACTION_FINISHED(act), .I_RATE_MEASURE_DONE(mdone),
        .I_PATTERN_SEED_READBACK(32'h89ABCDEF), .O_SIGNAL_LOSS_PIN(pin), .O_RECOVERY_LOOP_SELECT(sel),
        .O_LOCK_TO_REFERENCE(rfl), .O_RATE_MEASURE_START(mstart), .O_RATE_MEASURE_CLEAR(mclr),
        .O_ACQUISITION_RESTART(acq), .O_DEVICE_RESET(srst), .O_RECOVERY_PATH_SKIP(skip), .O_STATIC_LOCK_MODE(slk),
        .O_SIGNAL_DETECTOR_OFF(detoff), .O_REFERENCE_INPUT_OFF(refoff), .O_LOCK_COMPARE_SOURCE(cmp),
        .O_REFERENCE_BAND(band), .O_RATE_MULTIPLE(mult), .O_RATE_TO_REF_EXP(rexp));
    // Counting pulses catches both a missing and a doubled command strobe
    always @(posedge I_CLK) begin
        pulses[0] <= pulses[0] + int'(mstart);
        pulses[1] <= pulses[1] + int'(mclr);
        pulses[2] <= pulses[2] + int'(acq);
        pulses[3] <= pulses[3] + int'(srst);
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_host.rd(a, d);
        chk(d, exp);
    endtask
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic t_defaults();
        chk({7'h0, refoff}, 8'h01);
        rdchk(8'h08, 8'h00);
        rdchk(8'h09, 8'h00);
        rdchk(8'h0A, 8'h05);
        rdchk(8'h0F, 8'h00);
        rdchk(8'h48, 8'h11);
        rdchk(8'h49, 8'h22);
        rdchk(8'h30, 8'h00);
        for (int i = 0; i < 4; i++) begin
            rdchk(8'h42 + 8'(i), 8'(32'h89ABCDEF >> (8 * i)));
        end
    endtask
    task automatic t_status();
        sig <= 1'b1;
        lck <= 1'b1;
        act <= 1'b1;
        mdone <= 1'b1;
        @(posedge I_CLK);
        mdone <= 1'b0;
        rdchk(8'h06, 8'h3D);
        chk({7'h0, pin}, 8'h01);
        lck <= 1'b0;
        act <= 1'b0;
        rdchk(8'h06, 8'h25);
        i_host.wr(8'h08, 8'h04);
        rdchk(8'h06, 8'h21);
        i_host.wr(8'h08, 8'h01);
        rdchk(8'h06, 8'h20);
        chk(8'(pulses[1]), 8'h01);
    endtask
    task automatic t_control();
        i_host.wr(8'h08, 8'h02);
        chk(8'(pulses[0]), 8'h01);
        i_host.wr(8'h08, 8'h20);
        chk({4'h0, rfl, sel}, 8'h0A);
        i_host.wr(8'h08, 8'h00);
        chk({4'h0, rfl, sel}, 8'h00);
        i_host.wr(8'h09, 8'h24);
        chk({6'h0, skip, pin}, 8'h02);
        i_host.wr(8'h09, 8'h1C);
        chk({5'h0, slk, detoff, pin}, 8'h07);
        rdchk(8'h06, 8'h00);
        i_host.wr(8'h09, 8'h40);
        i_host.wr(8'h09, 8'h00);
        chk(8'(pulses[2]), 8'h01);
        i_host.wr(8'h0A, 8'h01);
        chk({7'h0, refoff}, 8'h00);
        i_host.wr(8'h0F, 8'h5A);
        chk({1'b0, cmp, band, mult}, 8'h5A);
        chk({3'h0, rexp}, 8'h08);
        i_host.wr(8'h0F, 8'h30);
        chk({3'h0, rexp}, 8'h1C);
        i_host.wr(8'h09, 8'h80);
        i_host.wr(8'h09, 8'h00);
        chk(8'(pulses[3]), 8'h01);
        rdchk(8'h0A, 8'h05);
        rdchk(8'h0F, 8'h00);
    endtask
    initial begin
        repeat (6) @(posedge I_CLK);
        I_RESETN <= 1'b1;
        @(posedge I_CLK);
        t_defaults();
        t_status();
        t_control();
        stop_test();
    end
    // About 32 transfers of under 400 cycles each fit well inside this span
    initial begin
        #(60000 * 50);
        err_total++;
        stop_test();
    end
endmodule
